// *** design/asp_pkg.sv ***
// Shared constants and types for the sample pipeline output block.
// Assumes a single 10 MHz system clock and an asynchronous active-low reset.
package asp_pkg;

  // ==========================================================================
  // Data layout
  localparam int COARSE_W = 5;
  localparam int FINE_W = 6;
  localparam int WORD_W = 10;
  // FIFO entry: {positive overdrive, negative overdrive, corrected word}.
  localparam int ENTRY_W = WORD_W + 2;
  localparam int ENTRY_POS_BIT = WORD_W + 1;
  localparam int ENTRY_NEG_BIT = WORD_W;
  localparam logic [11:0] FINE_OFFSET = 12'h010;
  localparam logic [9:0] FULL_POS = 10'h1FF;
  localparam logic [9:0] FULL_NEG = 10'h200;
  localparam logic [9:0] WORD_RESET = 10'h000;

  // ==========================================================================
  // Pipeline and timing
  localparam int PIPE_DEPTH = 3;
  localparam int VALID_EDGE = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 100;
  localparam int STOP_TIME_NS = 1000;
  localparam int STOP_CYC = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_TIME_NS = 3;
  localparam int RECOVER_CYC_RAW = RECOVER_TIME_NS / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (RECOVER_CYC_RAW < 1) ? 1 : RECOVER_CYC_RAW;

  // ==========================================================================
  // Strobe activity state
  typedef enum logic [0:0] {
    ST_STOPPED = 1'b0,
    ST_RUN = 1'b1
  } asp_run_t;

endpackage

// *** design/asp_fifo.sv ***
// Parameterised flip-flop FIFO with valid/ready on both sides and a flush.
// Assumes one clock domain; flush wins over push and pop in the same cycle.
`timescale 1ns/1ps
module asp_fifo #(
  parameter int W = 12,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_flush,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data,
  output logic [$clog2(D+1)-1:0] o_count
);

  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);

  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [CW-1:0] cnt_reg;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;

  assign o_ready = (cnt_reg != CW'(D));
  assign o_valid = (cnt_reg != '0);
  assign o_data = mem_reg[rd_reg];
  assign o_count = cnt_reg;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (i_flush) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= bump(wr_reg);
      end
      if (pop) begin
        rd_reg <= bump(rd_reg);
      end
      cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
    end
  end

  // Storage has no reset; entries are only read after being written.
  always_ff @(posedge i_clk) begin
    if (push && !i_flush) begin
      mem_reg[wr_reg] <= i_data;
    end
  end

endmodule

// *** design/asp_corr.sv ***
// Overlap correction of coarse and fine estimates into a two's-complement word.
// Purely combinational; the caller holds its inputs for the whole conversion.
`timescale 1ns/1ps
module asp_corr (
  // Raw estimates
  input wire logic [asp_pkg::COARSE_W-1:0] i_coarse,
  input wire logic [asp_pkg::FINE_W-1:0] i_fine,
  // Out-of-range comparators
  input wire logic i_over_pos,
  input wire logic i_over_neg,
  // Result
  output logic [asp_pkg::WORD_W-1:0] o_word,
  output logic o_over
);

  // The fine stage spans 64 codes over a 32-code coarse step, so a coarse
  // error of up to half a step either way is absorbed here.
  wire logic signed [11:0] sum = $signed({2'b00, i_coarse, 5'h00}) +
                                 $signed({6'h00, i_fine}) -
                                 $signed(asp_pkg::FINE_OFFSET);
  wire logic [9:0] unsigned_word = (sum < 0) ? 10'h000 :
                                   (sum > 12'sh3FF) ? 10'h3FF : sum[9:0];
  // Offset binary to two's complement: flip the most significant bit.
  wire logic [9:0] twos_word = {~unsigned_word[9], unsigned_word[8:0]};

  assign o_word = i_over_pos ? asp_pkg::FULL_POS :
                  i_over_neg ? asp_pkg::FULL_NEG : twos_word;
  assign o_over = i_over_pos || i_over_neg;

endmodule

// *** design/asp_top.sv ***
// Digital side of a ten-bit sampling converter: strobe-driven capture,
// overlap correction, a three-edge output pipeline, saturation and the
// range overflow flag.
// Assumes the strobe and the raw estimate pins are asynchronous to i_clk
// and that strobe edges are at least four i_clk cycles apart.
`timescale 1ns/1ps
module asp_top #(
  parameter bit HAS_RANGE_FLAG = 1'b1,
  parameter int STOP_CYC_P = asp_pkg::STOP_CYC,
  parameter int FIFO_D = asp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Conversion strobe and raw estimates from the analog front end
  input wire logic i_conv_strobe,
  input wire logic [asp_pkg::COARSE_W-1:0] i_coarse,
  input wire logic [asp_pkg::FINE_W-1:0] i_fine,
  input wire logic i_over_pos,
  input wire logic i_over_neg,
  // Output port toward capture logic
  output logic [asp_pkg::WORD_W-1:0] o_sample_word,
  output logic o_range_over,
  output logic o_word_valid,
  output logic o_sample_lost
);

  // ==========================================================================
  // Input synchronisers
  localparam int RAW_W = asp_pkg::COARSE_W + asp_pkg::FINE_W + 3;
  logic [RAW_W-1:0] sync1_reg;
  logic [RAW_W-1:0] sync2_reg;
  logic strobe_prev_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      strobe_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {i_conv_strobe, i_over_pos, i_over_neg, i_coarse, i_fine};
      sync2_reg <= sync1_reg;
      strobe_prev_reg <= sync2_reg[RAW_W-1];
    end
  end

  wire logic strobe_s = sync2_reg[RAW_W-1];
  wire logic pos_s = sync2_reg[RAW_W-2];
  wire logic neg_s = sync2_reg[RAW_W-3];
  wire logic [asp_pkg::COARSE_W-1:0] coarse_s = sync2_reg[RAW_W-4 -: asp_pkg::COARSE_W];
  wire logic [asp_pkg::FINE_W-1:0] fine_s = sync2_reg[asp_pkg::FINE_W-1:0];
  // Only the rising edge matters, so the high-pulse width has no effect.
  wire logic strobe_edge = strobe_s && !strobe_prev_reg;

  // ==========================================================================
  // Strobe activity tracking
  asp_pkg::asp_run_t run_reg;
  asp_pkg::asp_run_t run_next;
  logic [15:0] idle_reg;
  logic [2:0] edge_cnt_reg;

  wire logic idle_done = (idle_reg >= 16'(STOP_CYC_P));
  wire logic restart_edge = strobe_edge && (run_reg == asp_pkg::ST_STOPPED);

  always_comb begin
    run_next = run_reg;
    case (run_reg)
      asp_pkg::ST_STOPPED: begin
        if (strobe_edge) begin
          run_next = asp_pkg::ST_RUN;
        end
      end
      asp_pkg::ST_RUN: begin
        if (idle_done) begin
          run_next = asp_pkg::ST_STOPPED;
        end
      end
      default: begin
        run_next = asp_pkg::ST_STOPPED;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_reg <= asp_pkg::ST_STOPPED;
      idle_reg <= '0;
      edge_cnt_reg <= '0;
    end else begin
      run_reg <= run_next;
      if (strobe_edge) begin
        idle_reg <= '0;
      end else if (!idle_done) begin
        idle_reg <= idle_reg + 16'h0001;
      end
      if (restart_edge) begin
        edge_cnt_reg <= 3'h1;
      end else if (strobe_edge && edge_cnt_reg != 3'h7) begin
        edge_cnt_reg <= edge_cnt_reg + 3'h1;
      end
    end
  end

  // ==========================================================================
  // Sample hold and correction
  logic [asp_pkg::COARSE_W-1:0] hold_coarse_reg;
  logic [asp_pkg::FINE_W-1:0] hold_fine_reg;
  logic hold_pos_reg;
  logic hold_neg_reg;
  logic hold_new_reg;
  logic [asp_pkg::WORD_W-1:0] corr_word;
  logic corr_over;

  // The held estimates stay fixed until the next edge, so the correction
  // sees one consistent sample for the whole conversion.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_coarse_reg <= '0;
      hold_fine_reg <= '0;
      hold_pos_reg <= 1'b0;
      hold_neg_reg <= 1'b0;
      hold_new_reg <= 1'b0;
    end else begin
      hold_new_reg <= strobe_edge;
      if (strobe_edge) begin
        hold_coarse_reg <= coarse_s;
        hold_fine_reg <= fine_s;
        hold_pos_reg <= pos_s;
        hold_neg_reg <= neg_s;
      end
    end
  end

  asp_corr u_corr (
    .i_coarse(hold_coarse_reg),
    .i_fine(hold_fine_reg),
    .i_over_pos(hold_pos_reg),
    .i_over_neg(hold_neg_reg),
    .o_word(corr_word),
    .o_over(corr_over)
  );

  // ==========================================================================
  // Pipeline FIFO
  localparam int CW = $clog2(FIFO_D + 1);
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [asp_pkg::ENTRY_W-1:0] fifo_out;
  logic [CW-1:0] fifo_count;

  // A sample pushed on edge N is the oldest of three entries at edge N+3.
  wire logic pop = strobe_edge && !restart_edge &&
                   (fifo_count >= CW'(asp_pkg::PIPE_DEPTH));
  wire logic push_lost = hold_new_reg && !fifo_in_ready;

  asp_fifo #(
    .W(asp_pkg::ENTRY_W),
    .D(FIFO_D)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_flush(restart_edge),
    .i_valid(hold_new_reg),
    .o_ready(fifo_in_ready),
    .i_data({hold_pos_reg, hold_neg_reg, corr_word}),
    .o_valid(fifo_out_valid),
    .i_ready(pop),
    .o_data(fifo_out),
    .o_count(fifo_count)
  );

  // ==========================================================================
  // Output latch
  wire logic entry_over = fifo_out[asp_pkg::ENTRY_POS_BIT] || fifo_out[asp_pkg::ENTRY_NEG_BIT];

  // Word and flag change together on the release edge, so a capture stage
  // on the following edge always sees a matched pair.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sample_word <= asp_pkg::WORD_RESET;
      o_range_over <= 1'b0;
      o_word_valid <= 1'b0;
      o_sample_lost <= 1'b0;
    end else begin
      if (restart_edge) begin
        o_word_valid <= 1'b0;
      end else if (pop && fifo_out_valid) begin
        o_sample_word <= fifo_out[asp_pkg::WORD_W-1:0];
        o_range_over <= HAS_RANGE_FLAG && entry_over;
        o_word_valid <= 1'b1;
      end
      if (push_lost) begin
        o_sample_lost <= 1'b1;
      end else if (restart_edge) begin
        o_sample_lost <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Assertions
  property p_word_on_edge;
    @(posedge i_clk) disable iff (!i_rst_n)
      $changed(o_sample_word) |-> $past(strobe_edge);
  endproperty
  a_word_on_edge: assert property (p_word_on_edge)
    else $error("Output word changed without a strobe edge.");

  property p_latency;
    @(posedge i_clk) disable iff (!i_rst_n)
      (strobe_edge && run_reg == asp_pkg::ST_RUN && fifo_count == CW'(3)) |=>
        (o_word_valid && o_sample_word == $past(fifo_out[asp_pkg::WORD_W-1:0]));
  endproperty
  a_latency: assert property (p_latency)
    else $error("Released word is not the oldest pipelined sample.");

  property p_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      strobe_edge |=> (hold_coarse_reg == $past(coarse_s) && hold_fine_reg == $past(fine_s));
  endproperty
  a_hold: assert property (p_hold)
    else $error("Sample not captured on the strobe edge.");

  property p_sat_pos;
    @(posedge i_clk) disable iff (!i_rst_n)
      hold_pos_reg |-> (corr_word == asp_pkg::FULL_POS && corr_over);
  endproperty
  a_sat_pos: assert property (p_sat_pos)
    else $error("Positive overdrive did not saturate.");

  property p_sat_neg;
    @(posedge i_clk) disable iff (!i_rst_n)
      (hold_neg_reg && !hold_pos_reg) |-> (corr_word == asp_pkg::FULL_NEG && corr_over);
  endproperty
  a_sat_neg: assert property (p_sat_neg)
    else $error("Negative overdrive did not saturate.");

  property p_recover;
    @(posedge i_clk) disable iff (!i_rst_n)
      (hold_new_reg && !hold_pos_reg && !hold_neg_reg) |-> !corr_over;
  endproperty
  a_recover: assert property (p_recover)
    else $error("Conversion did not leave saturation on an in-range sample.");

  property p_midscale;
    @(posedge i_clk) disable iff (!i_rst_n)
      (!corr_over && hold_coarse_reg == 5'h10 && hold_fine_reg == 6'h10) |->
        corr_word == 10'h000;
  endproperty
  a_midscale: assert property (p_midscale)
    else $error("Midscale sample did not correct to zero.");

  property p_flag_out;
    @(posedge i_clk) disable iff (!i_rst_n)
      (pop && fifo_out_valid && entry_over) |=> (o_range_over == HAS_RANGE_FLAG);
  endproperty
  a_flag_out: assert property (p_flag_out)
    else $error("Range flag does not follow the released sample.");

  property p_no_flag_pin;
    @(posedge i_clk) disable iff (!i_rst_n)
      !HAS_RANGE_FLAG |-> !o_range_over;
  endproperty
  a_no_flag_pin: assert property (p_no_flag_pin)
    else $error("Range flag driven in the variant without it.");

  property p_first_valid;
    @(posedge i_clk) disable iff (!i_rst_n)
      $rose(o_word_valid) |-> edge_cnt_reg == 3'(asp_pkg::VALID_EDGE);
  endproperty
  a_first_valid: assert property (p_first_valid)
    else $error("First valid word not on the fourth edge after restart.");

  property p_flush;
    @(posedge i_clk) disable iff (!i_rst_n)
      restart_edge |=> (fifo_count == '0 && !o_word_valid);
  endproperty
  a_flush: assert property (p_flush)
    else $error("Pipeline not flushed on restart.");

  c_restart: cover property (@(posedge i_clk) disable iff (!i_rst_n) restart_edge);
  c_first_word: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_word_valid));
  c_overrange: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_range_over));
  c_stop: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_word_valid ##1 run_reg == asp_pkg::ST_STOPPED);

endmodule

// *** verif/asp_capture.sv ***
// Capture-side model: latches the sample word and the overflow flag on the strobe.
// Assumes the strobe idles low between bursts and shares i_clk's time base.
`timescale 1ns/1ps
module asp_capture #(
  parameter int STOP_CYC = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Output port of the converter
  input wire logic i_conv_strobe,
  input wire logic [asp_pkg::WORD_W-1:0] i_sample_word,
  input wire logic i_range_over,
  // Captured result
  output logic [asp_pkg::WORD_W-1:0] o_word,
  output logic o_flag,
  output logic [7:0] o_count
);
  logic [7:0] idle_reg;
  logic [3:0] edges_reg;

  // ==========================================================================
  // Idle measurement
  // A long low strobe means the clock stopped, so the next edge is a restart.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_reg <= 8'h00;
    end else if (i_conv_strobe) begin
      idle_reg <= 8'h00;
    end else if (idle_reg != 8'hFF) begin
      idle_reg <= idle_reg + 8'h01;
    end
  end

  // ==========================================================================
  // Capture on the strobe
  // The word is taken one edge late, after the converter's output has settled.
  always_ff @(posedge i_conv_strobe or negedge i_rst_n) begin
    if (!i_rst_n) begin
      edges_reg <= 4'h0;
      o_word <= '0;
      o_flag <= 1'b0;
      o_count <= 8'h00;
    end else begin
      if (idle_reg >= STOP_CYC) begin
        edges_reg <= 4'h1;
      end else if (edges_reg != 4'hF) begin
        edges_reg <= edges_reg + 4'h1;
      end
      if (idle_reg < STOP_CYC && edges_reg >= 4'h4) begin
        o_word <= i_sample_word;
        o_flag <= i_range_over;
        o_count <= o_count + 8'h01;
      end
    end
  end
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the sample pipeline output block.
// Assumes strobe periods of 14 clocks and a restart after 16 idle clocks.
`timescale 1ns/1ps
module tb;
  localparam int STOP = 16;
  localparam int PER = 14;
  localparam int LIMIT = 2000;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_conv_strobe = 1'b0;
  logic [4:0] i_coarse = 5'h00;
  logic [5:0] i_fine = 6'h00;
  logic i_over_pos = 1'b0;
  logic i_over_neg = 1'b0;
  logic [9:0] o_sample_word, nf_word, cap_word;
  logic o_range_over, o_word_valid, o_sample_lost, nf_over, cap_flag;
  logic [7:0] cap_count;
  logic [4:0] c_tab [8];
  logic [5:0] f_tab [8];
  logic p_tab [8];
  logic n_tab [8];
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;

  // ==========================================================================
  // Instances
  asp_top #(.STOP_CYC_P(STOP)) u_asp_top (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_conv_strobe(i_conv_strobe), .i_coarse(i_coarse), .i_fine(i_fine),
    .i_over_pos(i_over_pos), .i_over_neg(i_over_neg), .o_sample_word(o_sample_word),
    .o_range_over(o_range_over), .o_word_valid(o_word_valid), .o_sample_lost(o_sample_lost));
  asp_top #(.HAS_RANGE_FLAG(1'b0), .STOP_CYC_P(STOP)) u_asp_top_noflag (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_conv_strobe(i_conv_strobe), .i_coarse(i_coarse), .i_fine(i_fine),
    .i_over_pos(i_over_pos), .i_over_neg(i_over_neg), .o_sample_word(nf_word),
    .o_range_over(nf_over), .o_word_valid(), .o_sample_lost());
  asp_capture #(.STOP_CYC(STOP)) u_asp_capture (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_conv_strobe(i_conv_strobe), .i_sample_word(o_sample_word), .i_range_over(o_range_over),
    .o_word(cap_word), .o_flag(cap_flag), .o_count(cap_count));

  always #50 i_clk = ~i_clk;

  // ==========================================================================
  // Helpers
  function automatic logic [9:0] exp_word(input int i);
    int u;
    if (p_tab[i % 8]) return asp_pkg::FULL_POS;
    if (n_tab[i % 8]) return asp_pkg::FULL_NEG;
    u = int'(c_tab[i % 8]) * 32 + int'(f_tab[i % 8]) - 16;
    u = (u < 0) ? 0 : ((u > 1023) ? 1023 : u);
    return {~u[9], u[8:0]};
  endfunction

  function automatic logic exp_flag(input int i);
    return p_tab[i % 8] | n_tab[i % 8];
  endfunction

  task automatic chk(input logic bad, input string msg);
    num_checks++;
    if (bad) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // Estimates stay put from well before the rise until the next pulse begins.
  task automatic pulse(input int hw, input int k);
    @(posedge i_clk);
    i_coarse <= c_tab[k % 8];
    i_fine <= f_tab[k % 8];
    i_over_pos <= p_tab[k % 8];
    i_over_neg <= n_tab[k % 8];
    repeat (PER - hw - 1) @(posedge i_clk);
    i_conv_strobe <= 1'b1;
    repeat (hw) @(posedge i_clk);
    i_conv_strobe <= 1'b0;
    #1;
  endtask

  task automatic burst(input int hw, input int n);
    logic [7:0] cnt0;
    cnt0 = cap_count;
    repeat (STOP + 8) @(posedge i_clk);
    for (int k = 0; k < n; k++) begin
      pulse(hw, k);
      if (k < 3) begin
        chk(o_word_valid !== 1'b0, "valid before fourth edge");
      end else begin
        chk(o_word_valid !== 1'b1, "valid missing");
        chk(o_sample_word !== exp_word(k - 3), "sample word");
        chk(o_range_over !== exp_flag(k - 3), "overflow flag");
        chk(nf_word !== exp_word(k - 3), "flagless word");
        chk(nf_over !== 1'b0, "flagless flag");
      end
    end
    if (n > 4) begin
      chk(cap_count !== cnt0 + 8'(n - 4), "capture count");
      chk(cap_word !== exp_word(n - 5) || cap_flag !== exp_flag(n - 5), "captured pair");
    end
    chk(o_sample_lost !== 1'b0, "sample lost");
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_conv;
    c_tab = '{5'h10, 5'h00, 5'h1F, 5'h00, 5'h00, 5'h10, 5'h0F, 5'h1F};
    f_tab = '{6'h10, 6'h00, 6'h3F, 6'h0F, 6'h10, 6'h11, 6'h3F, 6'h2F};
    p_tab = '{default: 1'b0};
    n_tab = '{default: 1'b0};
    burst(7, 8);
  endtask

  task automatic t_duty;
    burst(6, 6);
    burst(8, 6);
  endtask

  // An aborted burst must leave nothing behind for the next one.
  task automatic t_restart;
    burst(7, 2);
    burst(7, 8);
  endtask

  task automatic t_sat;
    p_tab = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    n_tab = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    burst(7, 8);
  endtask

  // More samples than FIFO entries, so both FIFO pointers wrap inside one burst.
  task automatic t_fifo;
    burst(7, 12);
    repeat (STOP + 4) @(posedge i_clk);
    #1;
    chk(o_word_valid !== 1'b1, "valid dropped after stop");
    chk(o_sample_word !== exp_word(8) || o_range_over !== exp_flag(8), "word after stop");
  endtask

  // ==========================================================================
  // Verdict and sequencing
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      $display("unexpected at %0t: run too long", $time);
      results();
    end
  end

  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_conv();
    t_duty();
    t_restart();
    t_sat();
    t_fifo();
    results();
  end
endmodule
